/* File: design/flash_consts.vh */
// Constants for the serial flash command, status and sequencing logic
`ifndef FLASH_CONSTS_VH
`define FLASH_CONSTS_VH

// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OPC_PROG_THRU_B1 8'h82
`define OPC_PROG_THRU_B2 8'h85
`define OPC_REWRITE_B1   8'h58
`define OPC_REWRITE_B2   8'h59
`define OPC_STATUS       8'h57
`define OPC_XFER_B1      8'h53
`define OPC_XFER_B2      8'h55
`define OPC_COMP_B1      8'h60
`define OPC_COMP_B2      8'h61
`define OPC_PROG_ERA_B1  8'h83
`define OPC_PROG_ERA_B2  8'h86
`define OPC_PROG_NOE_B1  8'h88
`define OPC_PROG_NOE_B2  8'h89
`define OPC_PAGE_ERASE   8'h81
`define OPC_BLOCK_ERASE  8'h50
`define OPC_BUF_RD_B1    8'h54
`define OPC_BUF_RD_B2    8'h56
`define OPC_BUF_WR_B1    8'h84
`define OPC_BUF_WR_B2    8'h87

// ----------------------------------------------------------------------
// Framing and geometry
// ----------------------------------------------------------------------
`define OPC_LAST_BIT     6'd7
`define HDR_LAST_BIT     6'd31
`define RD_LAST_BIT      6'd39
`define BIT_CNT_SAT      6'd40
`define DATA_FIRST_BIT   6'd32
`define PAGE_MSB         21
`define PAGE_LSB         10
`define BUF_BYTES        11'd528
`define BUF_LAST         10'd527
`define BLK_LAST         3'd7
`define PROT_PAGES       13'd256
`define ERASED_BYTE      8'hff

// ----------------------------------------------------------------------
// Status byte
// ----------------------------------------------------------------------
`define ST_READY_BIT     7
`define ST_COMP_BIT      6
// Density code value is arbitrary
`define DENSITY_CODE     3'b011
`define ST_RESERVED      3'b000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ          200
`define XFR_TIME_US      250
`define EP_TIME_MS       10
`define P_TIME_MS        7
`define PE_TIME_MS       6
`define BE_TIME_MS       7
`define XFR_CYCLES       (`XFR_TIME_US * `CLK_MHZ)
`define EP_CYCLES        (`EP_TIME_MS * 1000 * `CLK_MHZ)
`define P_CYCLES         (`P_TIME_MS * 1000 * `CLK_MHZ)
`define PE_CYCLES        (`PE_TIME_MS * 1000 * `CLK_MHZ)
`define BE_CYCLES        (`BE_TIME_MS * 1000 * `CLK_MHZ)

`endif

/* File: design/pin_sync.v */
// Two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH    = 5,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] d,
    output wire [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule

/* File: design/op_timer.v */
// Down counter that times one self-timed array operation
`timescale 1ns/1ps
module op_timer #(
    parameter WIDTH = 32
) (
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire             clr,
    input  wire             load,
    input  wire [WIDTH-1:0] len,
    output wire             done
);
    reg [WIDTH-1:0] cnt_r;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= {WIDTH{1'b0}};
        end else if (clr) begin
            cnt_r <= {WIDTH{1'b0}};
        end else if (load) begin
            cnt_r <= len;
        end else if (cnt_r != {WIDTH{1'b0}}) begin
            cnt_r <= cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_r == {WIDTH{1'b0}});
endmodule

/* File: design/flash_prog_status_ctrl.v */
// Serial flash command decoder, buffers, status and array sequencer
`timescale 1ns/1ps
`include "flash_consts.vh"
module flash_prog_status_ctrl #(
    parameter XFR_CYCLES = `XFR_CYCLES,
    parameter EP_CYCLES  = `EP_CYCLES,
    parameter P_CYCLES   = `P_CYCLES,
    parameter PE_CYCLES  = `PE_CYCLES,
    parameter BE_CYCLES  = `BE_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        cs_b,
    input  wire        sck,
    input  wire        si,
    input  wire        wp_b,
    input  wire        chip_reset_b,
    output wire        so,
    output wire        so_oe_b,
    output wire        rdy_busy,
    output wire        rdy_busy_oe_b,
    output wire        spi_mode3,
    output wire [11:0] arr_page,
    output wire [9:0]  arr_byte,
    output wire [7:0]  arr_wdata,
    output wire        arr_we,
    input  wire [7:0]  arr_rdata
);
    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    // {array op, xfer, compare, erase, program, block, buffer 2}
    function [6:0] op_flags;
        input [7:0] o;
        begin
            case (o)
                `OPC_XFER_B1:      op_flags = 7'b1100000;
                `OPC_XFER_B2:      op_flags = 7'b1100001;
                `OPC_COMP_B1:      op_flags = 7'b1010000;
                `OPC_COMP_B2:      op_flags = 7'b1010001;
                `OPC_PROG_ERA_B1:  op_flags = 7'b1001100;
                `OPC_PROG_ERA_B2:  op_flags = 7'b1001101;
                `OPC_PROG_THRU_B1: op_flags = 7'b1001100;
                `OPC_PROG_THRU_B2: op_flags = 7'b1001101;
                `OPC_PROG_NOE_B1:  op_flags = 7'b1000100;
                `OPC_PROG_NOE_B2:  op_flags = 7'b1000101;
                `OPC_PAGE_ERASE:   op_flags = 7'b1001000;
                `OPC_BLOCK_ERASE:  op_flags = 7'b1001010;
                `OPC_REWRITE_B1:   op_flags = 7'b1101100;
                `OPC_REWRITE_B2:   op_flags = 7'b1101101;
                default:           op_flags = 7'b0000000;
            endcase
        end
    endfunction

    // {buffer write, buffer read, status, buffer 2}
    function [3:0] buf_flags;
        input [7:0] o;
        begin
            case (o)
                `OPC_BUF_WR_B1:    buf_flags = 4'b1000;
                `OPC_BUF_WR_B2:    buf_flags = 4'b1001;
                `OPC_PROG_THRU_B1: buf_flags = 4'b1000;
                `OPC_PROG_THRU_B2: buf_flags = 4'b1001;
                `OPC_BUF_RD_B1:    buf_flags = 4'b0100;
                `OPC_BUF_RD_B2:    buf_flags = 4'b0101;
                `OPC_STATUS:       buf_flags = 4'b0010;
                default:           buf_flags = 4'b0000;
            endcase
        end
    endfunction

    function [10:0] buf_index;
        input       sel;
        input [9:0] p;
        begin
            buf_index = sel ? ({1'b0, p} + `BUF_BYTES) : {1'b0, p};
        end
    endfunction

    function [9:0] next_ptr;
        input [9:0] p;
        begin
            next_ptr = (p >= `BUF_LAST) ? 10'd0 : p + 10'd1;
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    localparam S_IDLE  = 3'd0;
    localparam S_XFER  = 3'd1;
    localparam S_COMP  = 3'd2;
    localparam S_ERASE = 3'd3;
    localparam S_PROG  = 3'd4;
    localparam S_WAIT  = 3'd5;

    wire [4:0] pin_s;
    wire       cs_s;
    wire       sck_s;
    wire       si_s;
    wire       wp_s;
    wire       hold;
    reg        cs_q_r;
    reg        sck_q_r;

    pin_sync #(.WIDTH(5), .RST_VAL(5'h1f)) u_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d       ({chip_reset_b, wp_b, si, sck, cs_b}),
        .q       (pin_s)
    );

    assign cs_s  = pin_s[0];
    assign sck_s = pin_s[1];
    assign si_s  = pin_s[2];
    assign wp_s  = pin_s[3];
    assign hold  = ~pin_s[4];

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_q_r  <= 1'b1;
            sck_q_r <= 1'b1;
        end else begin
            cs_q_r  <= cs_s;
            sck_q_r <= sck_s;
        end
    end

    wire cs_fall  = cs_q_r & ~cs_s;
    wire cs_rise  = ~cs_q_r & cs_s;
    wire sck_rise = ~sck_q_r & sck_s & ~cs_s;
    wire sck_fall = sck_q_r & ~sck_s & ~cs_s;

    // ------------------------------------------------------------------
    // Serial side state
    // ------------------------------------------------------------------
    reg         mode3_r;
    reg         sel_r;
    reg  [5:0]  cnt_r;
    reg  [30:0] sh_r;
    reg  [7:0]  opc_r;
    reg  [11:0] page_r;
    reg  [9:0]  ptr_r;
    reg         hdr_ok_r;
    reg         out_on_r;
    reg  [2:0]  out_cnt_r;
    reg  [6:0]  out_sr_r;
    reg         so_r;
    reg         so_oe_b_r;
    reg  [7:0]  buf_mem [0:1055];

    reg  [2:0]  seq_r;
    reg         comp_r;
    wire        ready = (seq_r == S_IDLE);

    wire [31:0] sh_full = {sh_r, si_s};
    wire [3:0]  bf      = buf_flags(opc_r);
    wire [6:0]  fl      = op_flags(opc_r);
    // Fresh sample on every byte boundary
    wire [7:0]  status  = {ready, comp_r, `DENSITY_CODE, `ST_RESERVED};
    wire        wr_fire = sck_rise & sel_r & bf[3] & (cnt_r == `RD_LAST_BIT) & ~hold;
    wire [7:0]  rd_byte = (ptr_r < `BUF_BYTES) ? buf_mem[buf_index(bf[0], ptr_r)] : 8'h00;
    wire [7:0]  out_byte = bf[1] ? status : rd_byte;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode3_r   <= 1'b1;
            sel_r     <= 1'b0;
            cnt_r     <= 6'd0;
            sh_r      <= 31'd0;
            opc_r     <= 8'h00;
            page_r    <= 12'h000;
            ptr_r     <= 10'd0;
            hdr_ok_r  <= 1'b0;
            out_on_r  <= 1'b0;
            out_cnt_r <= 3'd0;
            out_sr_r  <= 7'd0;
            so_r      <= 1'b1;
            so_oe_b_r <= 1'b1;
        end else if (hold || cs_rise) begin
            // Partial headers die here; output released
            if (hold) begin
                mode3_r <= 1'b1;
            end
            sel_r     <= 1'b0;
            hdr_ok_r  <= 1'b0;
            out_on_r  <= 1'b0;
            so_oe_b_r <= 1'b1;
        end else if (cs_fall) begin
            mode3_r  <= sck_s;
            sel_r    <= 1'b1;
            cnt_r    <= 6'd0;
            hdr_ok_r <= 1'b0;
            out_on_r <= 1'b0;
        end else if (sel_r) begin
            if (sck_rise) begin
                sh_r <= sh_full[30:0];
                if (cnt_r == `RD_LAST_BIT && bf[3]) begin
                    cnt_r <= `DATA_FIRST_BIT;
                end else if (cnt_r != `BIT_CNT_SAT) begin
                    cnt_r <= cnt_r + 6'd1;
                end
                if (cnt_r == `OPC_LAST_BIT) begin
                    opc_r <= sh_full[7:0];
                    if (sh_full[7:0] == `OPC_STATUS) begin
                        out_on_r  <= 1'b1;
                        out_cnt_r <= 3'd0;
                    end
                end
                if (cnt_r == `HDR_LAST_BIT) begin
                    page_r   <= sh_full[`PAGE_MSB:`PAGE_LSB];
                    ptr_r    <= sh_full[9:0];
                    hdr_ok_r <= 1'b1;
                end
                if (cnt_r == `RD_LAST_BIT && bf[2]) begin
                    out_on_r  <= 1'b1;
                    out_cnt_r <= 3'd0;
                end
                if (wr_fire) begin
                    ptr_r <= next_ptr(ptr_r);
                end
            end else if (out_on_r && sck_fall) begin
                so_oe_b_r <= 1'b0;
                if (out_cnt_r == 3'd0) begin
                    // Each pass reloads, so polled status is sampled afresh at each byte boundary
                    so_r      <= out_byte[7];
                    out_sr_r  <= out_byte[6:0];
                    out_cnt_r <= 3'd7;
                    if (bf[2]) begin
                        ptr_r <= next_ptr(ptr_r);
                    end
                end else begin
                    so_r      <= out_sr_r[6];
                    out_sr_r  <= {out_sr_r[5:0], 1'b0};
                    out_cnt_r <= out_cnt_r - 3'd1;
                end
            end else if (out_on_r && bf[1] && out_cnt_r == 3'd7) begin
                so_r <= ready;
            end
        end
    end

    // ------------------------------------------------------------------
    // Array sequencer
    // ------------------------------------------------------------------
    reg  [6:0]  f_r;
    reg  [11:0] spage_r;
    reg  [9:0]  sidx_r;
    reg  [2:0]  blk_r;
    reg         mism_r;
    reg         cap_r;
    reg         cmpv_r;
    reg  [11:0] arr_page_r;
    reg  [9:0]  arr_byte_r;
    reg  [7:0]  arr_wdata_r;
    reg         arr_we_r;
    reg         rdy_oe_b_r;
    reg  [31:0] tm_len;
    wire        tm_done;

    wire prot   = ~wp_s & (fl[3] | fl[2]) & ({1'b0, page_r} < `PROT_PAGES);
    // Busy host commands are dropped rather than queued
    wire launch = cs_rise & sel_r & hdr_ok_r & fl[6] & ready & ~prot & ~hold;
    wire walk   = (seq_r == S_XFER) | (seq_r == S_COMP) | (seq_r == S_ERASE)
                | (seq_r == S_PROG);
    wire last   = (sidx_r == `BUF_LAST);

    always @* begin
        if (fl[5] && fl[3]) begin
            tm_len = EP_CYCLES;
        end else if (fl[5] || fl[4]) begin
            tm_len = XFR_CYCLES;
        end else if (fl[3] && fl[2]) begin
            tm_len = EP_CYCLES;
        end else if (fl[2]) begin
            tm_len = P_CYCLES;
        end else if (fl[1]) begin
            tm_len = BE_CYCLES;
        end else begin
            tm_len = PE_CYCLES;
        end
    end

    op_timer #(.WIDTH(32)) u_timer (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .clr     (hold),
        .load    (launch),
        .len     (tm_len),
        .done    (tm_done)
    );

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_r       <= S_IDLE;
            f_r         <= 7'd0;
            spage_r     <= 12'h000;
            sidx_r      <= 10'd0;
            blk_r       <= 3'd0;
            mism_r      <= 1'b0;
            comp_r      <= 1'b0;
            cap_r       <= 1'b0;
            cmpv_r      <= 1'b0;
            arr_page_r  <= 12'h000;
            arr_byte_r  <= 10'd0;
            arr_wdata_r <= 8'h00;
            arr_we_r    <= 1'b0;
            rdy_oe_b_r  <= 1'b1;
        end else if (hold) begin
            seq_r      <= S_IDLE;
            cap_r      <= 1'b0;
            cmpv_r     <= 1'b0;
            arr_we_r   <= 1'b0;
            rdy_oe_b_r <= 1'b1;
        end else begin
            rdy_oe_b_r <= ready & ~launch;
            cap_r      <= (seq_r == S_XFER);
            cmpv_r     <= (seq_r == S_COMP);
            arr_we_r   <= (seq_r == S_ERASE) | (seq_r == S_PROG);
            if (walk) begin
                arr_byte_r <= sidx_r;
                arr_page_r <= f_r[1] ? {spage_r[11:3], blk_r} : spage_r;
                sidx_r     <= last ? 10'd0 : sidx_r + 10'd1;
            end
            if (seq_r == S_ERASE) begin
                arr_wdata_r <= `ERASED_BYTE;
            end else begin
                arr_wdata_r <= buf_mem[buf_index(f_r[0], sidx_r)];
            end
            if (cmpv_r && buf_mem[buf_index(f_r[0], arr_byte_r)] != arr_rdata) begin
                mism_r <= 1'b1;
            end
            case (seq_r)
                S_IDLE: begin
                    if (launch) begin
                        f_r     <= fl;
                        spage_r <= page_r;
                        sidx_r  <= 10'd0;
                        blk_r   <= 3'd0;
                        mism_r  <= 1'b0;
                        if (fl[5]) begin
                            seq_r <= S_XFER;
                        end else if (fl[4]) begin
                            seq_r <= S_COMP;
                        end else if (fl[3]) begin
                            seq_r <= S_ERASE;
                        end else begin
                            seq_r <= S_PROG;
                        end
                    end
                end
                S_XFER: begin
                    if (last) begin
                        seq_r <= f_r[3] ? S_ERASE : S_WAIT;
                    end
                end
                S_COMP: begin
                    if (last) begin
                        seq_r <= S_WAIT;
                    end
                end
                S_ERASE: begin
                    if (last && f_r[1] && blk_r != `BLK_LAST) begin
                        blk_r <= blk_r + 3'd1;
                    end else if (last) begin
                        seq_r <= f_r[2] ? S_PROG : S_WAIT;
                    end
                end
                S_PROG: begin
                    if (last) begin
                        seq_r <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (tm_done && !cmpv_r) begin
                        seq_r <= S_IDLE;
                        if (f_r[4]) begin
                            comp_r <= mism_r;
                        end
                    end
                end
                default: seq_r <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Buffer storage: serial write port and transfer capture port
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (wr_fire && ptr_r < `BUF_BYTES) begin
            buf_mem[buf_index(bf[0], ptr_r)] <= sh_full[7:0];
        end
        if (cap_r) begin
            buf_mem[buf_index(f_r[0], arr_byte_r)] <= arr_rdata;
        end
    end

    assign so            = so_r;
    assign so_oe_b       = so_oe_b_r;
    assign rdy_busy      = 1'b0;
    assign rdy_busy_oe_b = rdy_oe_b_r;
    assign spi_mode3     = mode3_r;
    assign arr_page      = arr_page_r;
    assign arr_byte      = arr_byte_r;
    assign arr_wdata     = arr_wdata_r;
    assign arr_we        = arr_we_r;
endmodule

/* File: sim/flash_ctrl_monitor.sv */
// Concurrent checks on the flash controller pins and array port
`timescale 1ns/1ps
module flash_ctrl_monitor #(
    parameter EP_CYCLES = 3000
) (
    input wire       sys_clk,
    input wire       rst_b,
    input wire       cs_b,
    input wire       sck,
    input wire       chip_reset_b,
    input wire       so_oe_b,
    input wire       rdy_busy,
    input wire       rdy_busy_oe_b,
    input wire       spi_mode3,
    input wire [9:0] arr_byte,
    input wire [7:0] arr_wdata,
    input wire       arr_we
);
    // ------------------------------------------------------------------
    // Busy length counter and properties
    // ------------------------------------------------------------------
    reg [31:0] busy_len_r;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_len_r <= 32'h0;
        end else begin
            busy_len_r <= rdy_busy_oe_b ? 32'h0 : busy_len_r + 32'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_fall_hi;
        $fell(cs_b) && sck;
    endsequence
    sequence s_fall_lo;
        $fell(cs_b) && !sck;
    endsequence
    AST_RB_LOW: assert property (rdy_busy == 1'b0)
        else $error("ready pin data not low");
    AST_CS_IDLE: assert property (cs_b [*5] |-> so_oe_b)
        else $error("so driven while deselected");
    AST_CHIP_RST: assert property (!chip_reset_b [*5] |-> rdy_busy_oe_b && spi_mode3)
        else $error("chip reset did not idle");
    AST_MODE3: assert property (s_fall_hi |-> ##[3:6] spi_mode3)
        else $error("mode 3 not picked");
    AST_MODE0: assert property (s_fall_lo |-> ##[3:6] !spi_mode3)
        else $error("mode 0 not picked");
    AST_WE_BUSY: assert property (arr_we && chip_reset_b |-> ##1 !rdy_busy_oe_b)
        else $error("array written while ready");
    AST_ERASE_FIRST: assert property ($rose(arr_we) |-> arr_wdata == 8'hff)
        else $error("walk not started with erase");
    AST_BYTE_STEP: assert property (arr_we && $past(arr_we) |->
        arr_byte == $past(arr_byte) + 10'h1 || arr_byte == 10'h0)
        else $error("array byte not stepping");
    AST_BUSY_BOUND: assert property (busy_len_r <= EP_CYCLES + 4)
        else $error("busy too long");
endmodule

/* File: sim/flash_array_model.sv */
// Behavioural array store on the controller's array port
`timescale 1ns/1ps
module flash_array_model (
    input  wire        sys_clk,
    input  wire [11:0] arr_page,
    input  wire [9:0]  arr_byte,
    input  wire [7:0]  arr_wdata,
    input  wire        arr_we,
    output wire [7:0]  arr_rdata
);
    // Two page bits kept only: the bench uses four distinct pages
    reg [7:0] mem [0:4095];
    integer   n_wr;
    integer   i;
    initial begin
        n_wr = 0;
        for (i = 0; i < 4096; i = i + 1) begin
            mem[i] = 8'hff;
        end
    end
    assign arr_rdata = mem[{arr_page[1:0], arr_byte}];
    always @(posedge sys_clk) begin
        if (arr_we) begin
            mem[{arr_page[1:0], arr_byte}] <= arr_wdata;
            n_wr <= n_wr + 1;
        end
    end
endmodule

/* File: sim/flash_prog_status_ctrl_bench.sv */
// Self-checking bench for the flash command and status controller
`timescale 1ns/1ps
module flash_prog_status_ctrl_bench;
    reg         sys_clk, rst_b, cs_b, sck, si, wp_b, chip_reset_b;
    wire        so, so_oe_b, rdy_busy, rdy_busy_oe_b, spi_mode3, arr_we;
    // Released output shows the inverse, so stale data never passes
    wire        so_pin = so_oe_b ? ~so : so;
    wire [11:0] arr_page;
    wire [9:0]  arr_byte;
    wire [7:0]  arr_wdata, arr_rdata;
    integer     n_errors, samples_checked, w;
    reg  [7:0]  r, s;
    flash_prog_status_ctrl #(.XFR_CYCLES(3000), .EP_CYCLES(3000), .P_CYCLES(3000),
        .PE_CYCLES(3000), .BE_CYCLES(3000)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .cs_b(cs_b), .sck(sck), .si(si), .wp_b(wp_b), .chip_reset_b(chip_reset_b),
        .so(so), .so_oe_b(so_oe_b), .rdy_busy(rdy_busy), .rdy_busy_oe_b(rdy_busy_oe_b),
        .spi_mode3(spi_mode3), .arr_page(arr_page), .arr_byte(arr_byte),
        .arr_wdata(arr_wdata), .arr_we(arr_we), .arr_rdata(arr_rdata));
    flash_array_model mdl_u (.sys_clk(sys_clk), .arr_page(arr_page), .arr_byte(arr_byte),
        .arr_wdata(arr_wdata), .arr_we(arr_we), .arr_rdata(arr_rdata));
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task tick(input integer n); repeat (n) @(posedge sys_clk); endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Sck edges 8 cycles apart, so the 3-cycle output lag has settled
    task xb(input [7:0] b);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            sck <= 1'b0;
            si <= b[i];
            tick(8);
            r[i] = so_pin;
            sck <= 1'b1;
            tick(8);
        end
    endtask
    task cs_lo(input idle); begin sck <= idle; tick(4); cs_b <= 1'b0; tick(8); end endtask
    task cs_hi; begin tick(4); cs_b <= 1'b1; tick(8); end endtask
    task cmd(input [7:0] op, input [11:0] pg, input [9:0] by);
        begin
            cs_lo(1'b1);
            xb(op);
            xb({2'b00, pg[11:6]});
            xb({pg[5:0], by[9:8]});
            xb(by[7:0]);
        end
    endtask
    task stat(input idle);
        begin
            cs_lo(idle);
            chk(spi_mode3, idle);
            xb(8'h57);
            xb(8'h00);
            s = r;
            xb(8'h00);
            chk(r, s);
            chk(s[5:0], 6'h18);
            cs_hi;
        end
    endtask
    // Polls with sck parked low right after the top status bit
    task wait_ready(input busy);
        integer k;
        begin
            cs_lo(1'b1);
            xb(8'h57);
            sck <= 1'b0;
            tick(6);
            chk(so_oe_b, 1'b0);
            chk(so_pin, !busy);
            for (k = 0; k < 4000 && so_pin !== 1'b1; k = k + 1) tick(1);
            chk(so_pin, 1'b1);
            sck <= 1'b1;
            cs_hi;
            chk(rdy_busy_oe_b, 1'b1);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_rewrite_compare;
        begin
            w = mdl_u.n_wr;
            cmd(8'h58, 12'h122, 10'h3ff);
            cs_hi;
            chk(rdy_busy_oe_b, 1'b0);
            wait_ready(1'b1);
            chk(mdl_u.n_wr - w, 16'd1056);
            cmd(8'h60, 12'h122, 10'h000);
            cs_hi;
            wait_ready(1'b1);
            stat(1'b1);
            chk(s[7:6], 2'b10);
        end
    endtask
    task t_prog_wrap;
        begin
            cmd(8'h82, 12'h123, 10'h20e);
            xb(8'ha0);
            xb(8'ha1);
            xb(8'ha2);
            cs_hi;
            wait_ready(1'b1);
            chk(mdl_u.mem[{2'd3, 10'h20e}], 8'ha0);
            chk(mdl_u.mem[{2'd3, 10'h20f}], 8'ha1);
            chk(mdl_u.mem[{2'd3, 10'h000}], 8'ha2);
            chk(mdl_u.mem[{2'd3, 10'h001}], 8'hff);
            cmd(8'h60, 12'h122, 10'h000);
            cs_hi;
            wait_ready(1'b1);
            stat(1'b1);
            chk(s[6], 1'b1);
            cmd(8'h81, 12'h123, 10'h000);
            cs_hi;
            wait_ready(1'b1);
            chk(mdl_u.mem[{2'd3, 10'h20e}], 8'hff);
        end
    endtask
    task t_protect_concurrent;
        begin
            wp_b <= 1'b0;
            w = mdl_u.n_wr;
            cmd(8'h85, 12'h0ff, 10'h000);
            xb(8'h55);
            cs_hi;
            chk(rdy_busy_oe_b, 1'b1);
            cmd(8'h82, 12'h100, 10'h000);
            xb(8'h55);
            cs_hi;
            chk(rdy_busy_oe_b, 1'b0);
            wp_b <= 1'b1;
            cmd(8'h87, 12'h000, 10'h004);
            xb(8'h3c);
            cs_hi;
            cmd(8'h56, 12'h000, 10'h004);
            xb(8'h00);
            xb(8'h00);
            chk(r, 8'h3c);
            cs_hi;
            wait_ready(1'b1);
            chk(mdl_u.n_wr - w, 16'd1056);
            chk(mdl_u.mem[{2'd0, 10'h000}], 8'h55);
        end
    endtask
    task t_partial_reset;
        begin
            cs_lo(1'b1);
            xb(8'h83);
            xb(8'h01);
            cs_hi;
            chk(rdy_busy_oe_b, 1'b1);
            cmd(8'h83, 12'h101, 10'h000);
            cs_hi;
            tick(100);
            chip_reset_b <= 1'b0;
            tick(8);
            chk(rdy_busy_oe_b, 1'b1);
            chk(so_oe_b, 1'b1);
            chip_reset_b <= 1'b1;
            tick(8);
            stat(1'b0);
            chk(s[7], 1'b1);
            stat(1'b1);
        end
    endtask
    task conclude;
        begin
            if (n_errors == 0 && samples_checked > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        tick(90000);
        n_errors = n_errors + 1;
        conclude;
    end
    initial begin
        {rst_b, cs_b, sck, si, wp_b, chip_reset_b} = 6'b011111;
        n_errors = 0;
        samples_checked = 0;
        tick(8);
        rst_b <= 1'b1;
        tick(4);
        chk(so_oe_b, 1'b1);
        stat(1'b1);
        chk(s[7], 1'b1);
        t_rewrite_compare;
        t_prog_wrap;
        t_protect_concurrent;
        t_partial_reset;
        conclude;
    end
endmodule
bind flash_prog_status_ctrl flash_ctrl_monitor #(.EP_CYCLES(EP_CYCLES)) mon_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .chip_reset_b(chip_reset_b),
    .so_oe_b(so_oe_b), .rdy_busy(rdy_busy), .rdy_busy_oe_b(rdy_busy_oe_b),
    .spi_mode3(spi_mode3), .arr_byte(arr_byte), .arr_wdata(arr_wdata), .arr_we(arr_we));
